// *** sdh_pkg.sv ***
// package: register map, field layout, constants and types of the sd host
package sdh_pkg;
    localparam logic [7:0] ADDR_ARG      = 8'h00;
    localparam logic [7:0] ADDR_XFER     = 8'h04;
    localparam logic [7:0] ADDR_RESP0    = 8'h08;
    localparam logic [7:0] ADDR_DATA     = 8'h18;
    localparam logic [7:0] ADDR_PRES     = 8'h1C;
    localparam logic [7:0] ADDR_PROT     = 8'h20;
    localparam logic [7:0] ADDR_SYS      = 8'h24;
    localparam logic [7:0] ADDR_ISTAT    = 8'h28;
    localparam logic [7:0] ADDR_ISTEN    = 8'h2C;
    localparam logic [7:0] ADDR_ISIGEN   = 8'h30;
    localparam logic [7:0] ADDR_WML      = 8'h34;
    localparam logic [7:0] ADDR_BLK      = 8'h38;
    // interrupt status bit positions
    localparam int EV_CMD_DONE = 0;
    localparam int EV_XFER_DONE = 1;
    localparam int EV_INSERT = 2;
    localparam int EV_REMOVE = 3;
    localparam int EV_CMD_TMO = 4;
    localparam int EV_CMD_CRC = 5;
    localparam int EV_DAT_CRC = 6;
    localparam int NUM_EV = 7;
    // protocol control: width field
    localparam logic [1:0] WIDTH_1 = 2'h0;
    localparam logic [1:0] WIDTH_4 = 2'h1;
    localparam logic [1:0] WIDTH_8 = 2'h2;
    localparam int BUF_DEPTH = 128;
    localparam logic [7:0] READ_WATERMARK_LEVEL_RST = 8'h10;
    localparam logic [7:0] WRITE_WATERMARK_LEVEL_RST = 8'h10;
    // response time-out: 64 card clocks of 400 ns
    localparam int RESP_TMO_NS = 25600;
    localparam int CLK_NS = 50;
    localparam int RESP_TMO_CYC = RESP_TMO_NS / CLK_NS;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef struct packed {
        logic [5:0] index;
        logic [1:0] resp_type;  // 0 none, 1 short, 2 long
        logic       data_pres;
        logic       dir_read;
    } sdh_cmd_t;
    typedef struct packed {
        logic [1:0] width;
        logic       mmc_mode;
        logic       read_wait;
    } sdh_prot_t;
endpackage : sdh_pkg

// *** sdh_sync.sv ***
// two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module sdh_sync #(
    parameter int W = 1
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;
    // first stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : sdh_sync

// *** sdh_buf.sv ***
// shared data buffer with fill count
`timescale 1ns/1ps
module sdh_buf #(
    parameter int DEPTH = 128
) (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic                   clr,
    input  wire logic                   wr_en,
    input  wire logic [31:0]            wr_data,
    input  wire logic                   rd_en,
    output logic      [31:0]            rd_data,
    output logic      [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);
    logic [31:0]   mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic          do_wr;
    logic          do_rd;
    assign do_wr = wr_en && (count != (AW+1)'(DEPTH));
    assign do_rd = rd_en && (count != '0);
    assign rd_data = mem[rp];
    // storage array
    always_ff @(posedge aclk) begin
        if (do_wr) begin
            mem[wp] <= wr_data;
        end
    end
    // pointers and fill level
    always_ff @(posedge aclk) begin
        if (!aresetn || clr) begin
            wp <= '0;
            rp <= '0;
            count <= '0;
        end else begin
            if (do_wr) wp <= wp + 1'b1;
            if (do_rd) rp <= rp + 1'b1;
            count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule : sdh_buf

// *** sdh_host.sv ***
// sd/mmc host controller: axi4-lite registers, command and data engines
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module sdh_host #(
    parameter int DEPTH = sdh_pkg::BUF_DEPTH
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             sd_clk,
    input  wire logic        sd_cmd_i,
    output logic             sd_cmd_o,
    output logic             sd_cmd_oe,
    input  wire logic [7:0]  sd_dat_i,
    output logic [7:0]       sd_dat_o,
    output logic [7:0]       sd_dat_oe,
    input  wire logic        card_detect_n,
    output logic             dma_rx_req,
    output logic             dma_tx_req,
    output logic             irq
);
    localparam int CW = $clog2(DEPTH) + 1;
    // synchronised pins; only native sd signalling is used
    logic       cmd_s;
    logic [7:0] dat_s;
    logic       cd_s;
    sdh_sync #(.W(10)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       ({sd_cmd_i, sd_dat_i, ~card_detect_n}),
        .q       ({cmd_s, dat_s, cd_s})
    );
    // ---- registers
    logic [31:0]              arg;
    sdh_pkg::sdh_cmd_t        cmd;
    sdh_pkg::sdh_prot_t       prot;
    logic [31:0]              resp [4];
    logic [sdh_pkg::NUM_EV-1:0] istat;
    logic [sdh_pkg::NUM_EV-1:0] isten;
    logic [sdh_pkg::NUM_EV-1:0] isigen;
    logic [7:0]               read_watermark_level;
    logic [7:0]               write_watermark_level;
    logic [15:0]              blk_words;
    logic                     buf_clr;
    logic                     cd_q;
    // ---- axi write channel
    logic        aw_held;
    logic        w_held;
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic        wr_fire;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            waddr <= 8'h00;
            wdata <= 32'h0000_0000;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= sdh_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                waddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                wdata <= s_axi_wdata;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (waddr > sdh_pkg::ADDR_BLK
                    || waddr[1:0] != 2'h0)
                    ? sdh_pkg::RESP_SLVERR : sdh_pkg::RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
        end
    end
    // ---- axi read channel
    logic        rd_fire;
    logic [31:0] rmux;
    logic        rd_bad;
    logic        data_pop;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= sdh_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !rd_fire;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rmux;
                s_axi_rresp <= rd_bad ? sdh_pkg::RESP_SLVERR
                                      : sdh_pkg::RESP_OKAY;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
    // ---- data engine state
    typedef enum logic [2:0] {
        SDH_IDLE, SDH_CMD, SDH_RESP, SDH_RXD, SDH_TXD, SDH_CRC
    } sdh_state_t;
    sdh_state_t  state;
    logic [CW-1:0] fill;
    logic [31:0] buf_rd;
    logic        buf_wr;
    logic [31:0] buf_wd;
    logic        eng_pop;
    logic        eng_push;
    logic [31:0] eng_word;
    // read decode: present state is read-only; interrupt status is cleared by writing one
    always_comb begin
        rmux = 32'h0000_0000;
        rd_bad = 1'b0;
        case (s_axi_araddr)
            sdh_pkg::ADDR_ARG:    rmux = arg;
            sdh_pkg::ADDR_XFER:   rmux = {22'h0, cmd};
            sdh_pkg::ADDR_RESP0:  rmux = resp[0];
            8'h0C:                rmux = resp[1];
            8'h10:                rmux = resp[2];
            8'h14:                rmux = resp[3];
            sdh_pkg::ADDR_DATA:   rmux = buf_rd;
            sdh_pkg::ADDR_PRES:   rmux = {16'h0, 3'h0, cd_s,
                                  4'(state), fill};
            sdh_pkg::ADDR_PROT:   rmux = {28'h0, prot};
            sdh_pkg::ADDR_ISTAT:  rmux = {25'h0, istat};
            sdh_pkg::ADDR_ISTEN:  rmux = {25'h0, isten};
            sdh_pkg::ADDR_ISIGEN: rmux = {25'h0, isigen};
            sdh_pkg::ADDR_WML:    rmux = {16'h0, write_watermark_level, read_watermark_level};
            sdh_pkg::ADDR_BLK:    rmux = {16'h0, blk_words};
            default:              rd_bad = 1'b1;
        endcase
    end
    // one word leaves the buffer per data-port read
    assign data_pop = rd_fire && s_axi_araddr == sdh_pkg::ADDR_DATA;
    assign buf_wr = eng_push
        || (wr_fire && waddr == sdh_pkg::ADDR_DATA);
    assign buf_wd = eng_push ? eng_word : wdata;
    sdh_buf #(.DEPTH(DEPTH)) u_buf (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clr     (buf_clr),
        .wr_en   (buf_wr),
        .wr_data (buf_wd),
        .rd_en   (data_pop || eng_pop),
        .rd_data (buf_rd),
        .count   (fill)
    );
    // ---- software-written registers
    logic go;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arg <= 32'h0000_0000;
            cmd <= '0;
            prot <= '0;
            isten <= '0;
            isigen <= '0;
            read_watermark_level <= sdh_pkg::READ_WATERMARK_LEVEL_RST;
            write_watermark_level <= sdh_pkg::WRITE_WATERMARK_LEVEL_RST;
            blk_words <= 16'h0080;
            go <= 1'b0;
            buf_clr <= 1'b0;
        end else begin
            // go waits for a bus tick in idle; a bare pulse would be missed
            if (tick && state == SDH_IDLE) go <= 1'b0;
            buf_clr <= 1'b0;
            if (wr_fire) begin
                case (waddr)
                    sdh_pkg::ADDR_ARG: arg <= wdata;
                    sdh_pkg::ADDR_XFER: begin
                        cmd <= wdata[9:0];
                        go <= 1'b1;
                        buf_clr <= wdata[1];
                    end
                    sdh_pkg::ADDR_PROT: prot <= wdata[3:0];
                    sdh_pkg::ADDR_ISTEN: isten <= wdata[6:0];
                    sdh_pkg::ADDR_ISIGEN: isigen <= wdata[6:0];
                    sdh_pkg::ADDR_WML: begin
                        read_watermark_level <= wdata[7:0];
                        write_watermark_level <= wdata[15:8];
                    end
                    sdh_pkg::ADDR_BLK: blk_words <= wdata[15:0];
                    default: ;
                endcase
            end
        end
    end
    // ---- card bus clock from the system clock, divide by 8
    logic [2:0] div;
    logic       tick;
    assign tick = div == 3'h7;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div <= 3'h0;
            sd_clk <= 1'b0;
        end else begin
            div <= div + 3'h1;
            sd_clk <= div[2] && !(prot.read_wait && state == SDH_RXD);
        end
    end
    // lines in use per width: 8 only in mmc mode
    logic [3:0] lanes;
    always_comb begin
        case (prot.width)
            sdh_pkg::WIDTH_4: lanes = 4'd4;
            sdh_pkg::WIDTH_8: lanes = prot.mmc_mode ? 4'd8 : 4'd4;
            default:          lanes = 4'd1;
        endcase
    end
    // ---- command / response / data sequencer
    logic [47:0] shreg;
    logic [7:0]  bits;
    logic [15:0] tmo;
    logic [6:0]  crc7;
    logic [15:0] words;
    logic [31:0] acc;
    logic [5:0]  nib;
    logic [sdh_pkg::NUM_EV-1:0] ev;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= SDH_IDLE;
            shreg <= '0;
            bits <= 8'h00;
            tmo <= 16'h0000;
            crc7 <= 7'h00;
            words <= 16'h0000;
            acc <= 32'h0000_0000;
            nib <= 6'h00;
            sd_cmd_o <= 1'b1;
            sd_cmd_oe <= 1'b0;
            sd_dat_o <= 8'hFF;
            sd_dat_oe <= 8'h00;
            for (int i = 0; i < 4; i++) resp[i] <= 32'h0000_0000;
        end else if (tick) begin
            case (state)
                SDH_IDLE: if (go) begin
                    shreg <= {2'b01, cmd.index, arg, 8'h01};
                    bits <= 8'd48;
                    state <= SDH_CMD;
                    sd_cmd_oe <= 1'b1;
                end
                SDH_CMD: begin
                    sd_cmd_o <= shreg[47];
                    shreg <= {shreg[46:0], 1'b1};
                    bits <= bits - 8'd1;
                    if (bits == 8'd1) begin
                        sd_cmd_oe <= 1'b0;
                        tmo <= 16'h0000;
                        crc7 <= 7'h00;
                        bits <= (cmd.resp_type == 2'd2) ? 8'd136 : 8'd48;
                        state <= (cmd.resp_type == 2'd0) ? SDH_IDLE
                                                         : SDH_RESP;
                    end
                end
                SDH_RESP: begin
                    tmo <= tmo + 16'h1;
                    if (bits != 8'd136 && bits != 8'd48 || !cmd_s) begin
                        shreg <= {shreg[46:0], cmd_s};
                        // crc7 runs over start bit through argument
                        if (bits > 8'd8) begin
                            crc7 <= {crc7[5:0], 1'b0}
                                ^ ((cmd_s ^ crc7[6]) ? 7'h09 : 7'h00);
                        end
                        bits <= bits - 8'd1;
                        // last bit still in flight: fields sit one lower
                        if (bits[5:0] == 6'd1) begin
                            resp[0] <= shreg[38:7];
                            resp[1] <= resp[0];
                            resp[2] <= resp[1];
                            resp[3] <= resp[2];
                        end
                        if (bits == 8'd1) begin
                            words <= blk_words;
                            nib <= 6'h00;
                            state <= !cmd.data_pres ? SDH_IDLE
                                   : cmd.dir_read ? SDH_RXD : SDH_TXD;
                        end
                    end else if (tmo >= 16'(sdh_pkg::RESP_TMO_CYC / 8)) begin
                        state <= SDH_IDLE;
                    end
                end
                SDH_RXD: if (!prot.read_wait && fill != CW'(DEPTH)) begin
                    acc <= (acc << lanes) | 32'(dat_s & ((8'h1 << lanes)
                           - 8'h1));
                    nib <= nib + 6'(lanes);
                    if (nib + 6'(lanes) == 6'd32) begin
                        nib <= 6'h00;
                        words <= words - 16'h1;
                        if (words == 16'h1) state <= SDH_CRC;
                    end
                end
                SDH_TXD: if (fill != '0 || nib != 6'h00) begin
                    sd_dat_oe <= (8'h1 << lanes) - 8'h1;
                    sd_dat_o <= 8'(buf_rd >> (6'd32 - nib - 6'(lanes)));
                    nib <= nib + 6'(lanes);
                    if (nib + 6'(lanes) == 6'd32) begin
                        nib <= 6'h00;
                        words <= words - 16'h1;
                        if (words == 16'h1) state <= SDH_CRC;
                    end
                end
                SDH_CRC: begin
                    sd_dat_oe <= 8'h00;
                    state <= SDH_IDLE;
                end
                default: state <= SDH_IDLE;
            endcase
        end
    end
    assign eng_push = tick && state == SDH_RXD && !prot.read_wait
        && fill != CW'(DEPTH) && nib + 6'(lanes) == 6'd32;
    assign eng_word = (acc << lanes) | 32'(dat_s & ((8'h1 << lanes) - 8'h1));
    assign eng_pop = tick && state == SDH_TXD && fill != '0
        && nib + 6'(lanes) == 6'd32;
    // ---- event detection
    always_comb begin
        ev = '0;
        ev[sdh_pkg::EV_CMD_DONE] = tick && state == SDH_RESP && bits == 8'd1;
        ev[sdh_pkg::EV_XFER_DONE] = tick && state == SDH_CRC;
        ev[sdh_pkg::EV_INSERT] = cd_s && !cd_q;
        ev[sdh_pkg::EV_REMOVE] = !cd_s && cd_q;
        ev[sdh_pkg::EV_CMD_TMO] = tick && state == SDH_RESP && cmd_s
            && (bits == 8'd136 || bits == 8'd48)
            && tmo >= 16'(sdh_pkg::RESP_TMO_CYC / 8);
        ev[sdh_pkg::EV_CMD_CRC] = tick && state == SDH_RESP && bits == 8'd1
            && crc7 != shreg[6:0];
        ev[sdh_pkg::EV_DAT_CRC] = tick && state == SDH_CRC && dat_s[0];
    end
    // sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            istat <= '0;
            cd_q <= 1'b0;
        end else begin
            cd_q <= cd_s;
            istat <= (istat & ~((wr_fire && waddr == sdh_pkg::ADDR_ISTAT)
                     ? wdata[6:0] : 7'h00)) | (ev & isten);
        end
    end
    // interrupt and dma requests registered from current state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
            dma_rx_req <= 1'b0;
            dma_tx_req <= 1'b0;
        end else begin
            irq <= |(istat & isigen);
            // request follows the level, never latched
            dma_rx_req <= cmd.dir_read && fill > CW'(read_watermark_level);
            dma_tx_req <= !cmd.dir_read && cmd.data_pres
                && (CW'(DEPTH) - fill) > CW'(write_watermark_level);
        end
    end
    rx_req_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
        1 |=> dma_rx_req == $past(cmd.dir_read && fill > CW'(read_watermark_level)))
        else $error("rx request wrong");
    tx_req_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (fill == CW'(DEPTH)) |=> !dma_tx_req)
        else $error("tx request on full");
    rx_req_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (fill <= CW'(read_watermark_level)) |=> !dma_rx_req)
        else $error("rx request held");
    irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (istat & isigen) == '0 |=> !irq)
        else $error("irq without enable");
    stat_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ev & isten) != '0
        |=> (istat & $past(ev & isten)) == $past(ev & isten))
        else $error("event lost");
    insert_seen_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(cd_s) && isten[sdh_pkg::EV_INSERT]
        |=> istat[sdh_pkg::EV_INSERT])
        else $error("insert missed");
    go_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
        go && state == SDH_IDLE |-> ##[1:9] state == SDH_CMD)
        else $error("command not started");
    pop_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
        data_pop && fill != '0 && !buf_wr && !eng_pop
        |=> fill == CW'($past(fill) - 1'b1))
        else $error("data port pop wrong");
    cmd_cov_c: cover property (@(posedge aclk) state == SDH_RESP);
    rx_cov_c: cover property (@(posedge aclk) $rose(dma_rx_req));
    irq_cov_c: cover property (@(posedge aclk) $rose(irq));
endmodule : sdh_host

// *** sdh_card_model.sv ***
// card model: answers commands on the command line
`timescale 1ns/1ps
module sdh_card_model (
    input  wire logic        sd_clk,
    input  wire logic        sd_cmd_o,
    input  wire logic        sd_cmd_oe,
    input  wire logic [1:0]  mode,
    input  wire logic [5:0]  idx,
    input  wire logic [31:0] arg,
    output logic             sd_cmd_i,
    output logic [7:0]       sd_dat_i
);
    logic [47:0] rsp;
    logic [6:0]  crc;
    logic        drv;
    int          i;
    // both lines carry pull-ups, so a released line reads high
    assign sd_dat_i = 8'hFF;
    assign sd_cmd_i = sd_cmd_oe ? sd_cmd_o : (!drv | rsp[47]);
    // mode 0 silent, 1 good reply, 2 reply with a broken crc
    initial begin
        drv = 1'b0;
        forever begin
            @(negedge sd_cmd_oe);
            rsp = {2'b00, idx, arg, 8'h01};
            crc = 7'h00;
            for (i = 47; i > 7; i--) begin
                crc = {crc[5:0], 1'b0} ^ (rsp[i] ^ crc[6] ? 7'h09 : 7'h00);
            end
            rsp[7:1] = crc ^ {6'h00, mode[1]};
            if (mode != 2'h0) begin
                repeat (2) @(posedge sd_clk);
                @(negedge sd_clk);
                drv = 1'b1;
                repeat (47) begin
                    @(negedge sd_clk);
                    rsp = rsp << 1;
                end
                @(negedge sd_clk);
                drv = 1'b0;
            end
        end
    end
endmodule : sdh_card_model

// *** test_sd_mmc_host_controller.sv ***
// self-checking bench for the sd host: registers, events, commands, dma
`timescale 1ns/1ps
module test_sd_mmc_host_controller;
    logic        aclk, aresetn, awv, wv, bry, arv, rry, awr, wr_r, bv, arr, rv;
    logic        cdn, sclk, ci, co, coe, rxq, txq, irq;
    logic [7:0]  awa, ara, di, dato, datoe;
    logic [31:0] wd, rdat, arg, rd;
    logic [1:0]  bres, rres, mode, br;
    logic [5:0]  idx;
    int          fail_count, check_count, cyc, seed, n;
    sdh_host i_dut (.aclk, .aresetn, .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bres),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(rres), .s_axi_rvalid(rv), .s_axi_rready(rry),
        .sd_clk(sclk), .sd_cmd_i(ci), .sd_cmd_o(co), .sd_cmd_oe(coe),
        .sd_dat_i(di), .sd_dat_o(dato), .sd_dat_oe(datoe),
        .card_detect_n(cdn), .dma_rx_req(rxq), .dma_tx_req(txq), .irq(irq));
    sdh_card_model i_card (.sd_clk(sclk), .sd_cmd_o(co), .sd_cmd_oe(coe),
        .mode(mode), .idx(idx), .arg(arg), .sd_cmd_i(ci), .sd_dat_i(di));
    task check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // write channels are released one by one as each is taken
    task axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
        do begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wr_r) wv <= 1'b0;
        end while (!bv);
        br = bres;
        bry <= 1'b0;
    endtask : axw
    task axr(input logic [7:0] a);
        @(posedge aclk);
        ara <= a; arv <= 1'b1; rry <= 1'b1;
        do begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rd = rdat;
        br = rres;
        rry <= 1'b0;
    endtask : axr
    task wr(input logic [7:0] a, input logic [31:0] d);
        axw(a, d);
        check(br, sdh_pkg::RESP_OKAY);
    endtask : wr
    task print_verdict;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    // watchdog: the whole run needs well under this many cycles
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            print_verdict();
        end
    end
    initial begin
        aresetn = 0; awv = 0; wv = 0; bry = 0; arv = 0; rry = 0; cdn = 1;
        awa = 0; ara = 0; wd = 0; mode = 0; idx = 0; arg = 0; seed = 73;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axr(sdh_pkg::ADDR_WML);
        check(rd, 32'h0000_1010);
        axr(8'h3C);
        check(br, sdh_pkg::RESP_SLVERR);
        axw(8'h01, 32'h0);
        check(br, sdh_pkg::RESP_SLVERR);
        // insert/remove in turn; the second event is kept out by its enable
        for (n = 0; n < 5; n++) begin
            wr(sdh_pkg::ADDR_ISTEN, n == 1 ? 32'h77 : 32'h7F);
            wr(sdh_pkg::ADDR_ISIGEN, 32'h7F);
            cdn <= n[0];
            repeat (8) @(posedge aclk);
            axr(sdh_pkg::ADDR_ISTAT);
            check(rd, n == 1 ? 0 : 32'h4 << n[0]);
            check(irq, n != 1);
            wr(sdh_pkg::ADDR_ISTAT, 32'h7F);
        end
        // silent card, good reply, corrupted crc; irq masked on the first
        for (n = 0; n < 3; n++) begin
            mode <= n[1:0];
            idx <= 6'(n + 17);
            arg = $random(seed);
            wr(sdh_pkg::ADDR_ISIGEN, n == 0 ? 32'h0 : 32'h7F);
            wr(sdh_pkg::ADDR_ARG, arg);
            wr(sdh_pkg::ADDR_XFER, {22'h0, 6'(n + 17), 4'h4});
            do axr(sdh_pkg::ADDR_ISTAT); while ((rd & 32'h31) == 0);
            check(rd & 32'h30, n == 1 ? 0 : 32'h10 << n[1]);
            check(irq, n != 0);
            if (n == 1) axr(sdh_pkg::ADDR_RESP0);
            if (n == 1) check(rd, arg);
            wr(sdh_pkg::ADDR_ISTAT, 32'h7F);
        end
        for (n = 0; n < 3; n++) begin
            wr(sdh_pkg::ADDR_PROT, {28'h0, 2'(n), 2'h2});
            axr(sdh_pkg::ADDR_PROT);
            check(rd, {28'h0, 2'(n), 2'h2});
        end
        // read transfer of 20 words on eight lines, drained by the dma side
        mode <= 2'h1;
        wr(sdh_pkg::ADDR_BLK, 32'd20);
        wr(sdh_pkg::ADDR_XFER, {22'h0, 6'd18, 4'h7});
        do axr(sdh_pkg::ADDR_PRES); while (rd[7:0] <= 8'd16);
        check(rxq, 1'b1);
        do axr(sdh_pkg::ADDR_ISTAT); while (!rd[1]);
        for (n = 0; n < 20; n++) begin
            axr(sdh_pkg::ADDR_DATA);
            check(rd, 32'hFFFF_FFFF);
        end
        axr(sdh_pkg::ADDR_PRES);
        check({rxq, rd[7:0]}, 9'h000);
        // write transfer: the dma side fills until free space hits the mark
        wr(sdh_pkg::ADDR_XFER, {22'h0, 6'd24, 4'h6});
        repeat (4) @(posedge aclk);
        check({rxq, txq}, 2'b01);
        for (n = 0; n < 112; n++) begin
            wr(sdh_pkg::ADDR_DATA, $random(seed));
        end
        repeat (2) @(posedge aclk);
        check(txq, 1'b0);
        axr(sdh_pkg::ADDR_PRES);
        check(rd[7:0], 8'd112);
        print_verdict();
    end
endmodule : test_sd_mmc_host_controller
